// file: rtl/ebs_sequencer.sv
// External bus cycle sequencer for multiplexed four-state and eight-state strobe modes.
`timescale 1ns/100ps
// Behaviour
// - Mux read state one drives address on data bus and asserts chip select.
// - Latch enable rises at start of state one, falls at its middle.
// - Mux read state two releases data bus and asserts read strobe.
// - State two asserts memory or I/O request per access space.
// - Four-state cycle leaves bus signals unchanged in state three.
// - Wait pin low before state three inserts waits until it goes high.
// - Mux read state four captures data, releases read strobe, ends cycle.
// - Mux write state two puts write data on bus, asserts write strobe.
// - Write state four drops write strobe, holds buses until its end.
// - Strobe-mode chip selects run eight states, zero through seven.
// - State zero of an eight-state read drives read-not-write high.
// - Entering state one presents the full 24-bit address.
// - Edge starting state two asserts address and data strobes.
// - Eight-state read leaves bus signals unchanged in states three, five.
// - State four waits for transfer acknowledge, inserting waits until asserted.
// - Each eight-state wait lasts one full bus state period.
// - Four-state mode states last a configured 2 to 15 system clocks.
// - Entering state seven captures data and drops both strobes.
module ebs_sequencer #(
    parameter int ADDR_W = ebs_pkg::ADDR_W,
    parameter int DATA_W = ebs_pkg::DATA_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_strobe_mode_i,
    input wire logic req_write_i,
    input wire logic req_io_i,
    input wire logic [3:0] req_chip_sel_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [DATA_W-1:0] req_wdata_i,
    input wire logic [3:0] mux_state_clocks_i,
    input wire logic [3:0] stb_state_clocks_i,
    output logic done_o,
    output logic [DATA_W-1:0] rdata_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_n_o,
    input wire logic [DATA_W-1:0] data_i,
    output logic [3:0] chip_sel_n_o,
    output logic addr_latch_en_o,
    output logic read_n_o,
    output logic write_n_o,
    output logic memory_request_n_o,
    output logic io_space_request_n_o,
    output logic read_not_write_o,
    output logic address_strobe_n_o,
    output logic data_strobe_n_o,
    input wire logic wait_ack_n_i,
    output logic inserted_wait_state_o
);
    ebs_pkg::ebs_state_t state_ff;
    ebs_pkg::ebs_state_t nxt_state;
    ebs_tick_if tick ();

    logic write_ff;
    logic io_ff;
    logic [3:0] cs_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic done_ff;
    logic [3:0] mux_len_ff;
    logic [3:0] stb_len_ff;
    logic wait_seen_ff, wait_prev_ff, ack_early_ff, ack_prev_ff;

    logic data_oe_n_ff;
    logic [DATA_W-1:0] data_out_ff;
    logic ale_ff;
    logic read_n_ff;
    logic write_n_ff;
    logic mem_req_n_ff;
    logic io_req_n_ff;
    logic rnw_ff;
    logic astb_n_ff;
    logic dstb_n_ff;

    logic mux_mode, state_end, idle, take_req, in_t1;
    logic [3:0] mux_len_clamped;
    logic [3:0] stb_len_clamped;
    logic enter_t2, enter_t4, enter_s2, enter_s7, leave_t4, leave_s7;
    logic stretch_t3, stretch_s4;

    // The timer length follows the mode; the configured four-state length is clamped.
    assign mux_len_clamped = (mux_len_ff < ebs_pkg::MUX_STATE_MIN) ? ebs_pkg::MUX_STATE_MIN
                                                                     : mux_len_ff;
    assign stb_len_clamped = (stb_len_ff == 4'h0) ? 4'h1 : stb_len_ff;
    assign mux_mode = (state_ff == ebs_pkg::EBS_T1) || (state_ff == ebs_pkg::EBS_T2) ||
                      (state_ff == ebs_pkg::EBS_T3) || (state_ff == ebs_pkg::EBS_TW) ||
                      (state_ff == ebs_pkg::EBS_T4);
    assign tick.length = mux_mode ? mux_len_clamped : stb_len_clamped;
    // A mux wait ends on the pin, not the timer, so it holds the timer and T4 keeps its full length.
    assign tick.restart = idle || (state_ff == ebs_pkg::EBS_TW);
    assign state_end = tick.last;

    // Request acceptance only while the bus is idle.
    assign idle = (state_ff == ebs_pkg::EBS_IDLE);
    assign take_req = idle && req_valid_i;
    assign req_ready_o = idle;
    assign in_t1 = (state_ff == ebs_pkg::EBS_T1);

    // Wait decisions use the pin as sampled at least one clock before the state boundary.
    assign stretch_t3 = wait_seen_ff || !wait_prev_ff;
    assign stretch_s4 = !ack_early_ff;

    // Edges into the states where bus signals change.
    assign enter_t2 = in_t1 && state_end;
    assign enter_t4 = ((state_ff == ebs_pkg::EBS_T3) && state_end && !stretch_t3) ||
                      ((state_ff == ebs_pkg::EBS_TW) && wait_ack_n_i);
    assign enter_s2 = (state_ff == ebs_pkg::EBS_S1) && state_end;
    assign enter_s7 = (state_ff == ebs_pkg::EBS_S6) && state_end;
    assign leave_t4 = (state_ff == ebs_pkg::EBS_T4) && state_end;
    assign leave_s7 = (state_ff == ebs_pkg::EBS_S7) && state_end;

    // State transitions; strobe waits step a whole state, mux waits end on the pin.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ebs_pkg::EBS_IDLE: begin
                if (req_valid_i) begin
                    nxt_state = req_strobe_mode_i ? ebs_pkg::EBS_S0 : ebs_pkg::EBS_T1;
                end
            end
            ebs_pkg::EBS_T1: begin
                if (state_end) begin
                    nxt_state = ebs_pkg::EBS_T2;
                end
            end
            ebs_pkg::EBS_T2: begin
                if (state_end) begin
                    nxt_state = ebs_pkg::EBS_T3;
                end
            end
            ebs_pkg::EBS_T3: begin
                if (state_end) begin
                    nxt_state = stretch_t3 ? ebs_pkg::EBS_TW : ebs_pkg::EBS_T4;
                end
            end
            ebs_pkg::EBS_TW: begin
                if (wait_ack_n_i) begin
                    nxt_state = ebs_pkg::EBS_T4;
                end
            end
            ebs_pkg::EBS_T4: begin
                if (state_end) begin
                    nxt_state = ebs_pkg::EBS_IDLE;
                end
            end
            ebs_pkg::EBS_S0: begin
                if (state_end) begin
                    nxt_state = ebs_pkg::EBS_S1;
                end
            end
            ebs_pkg::EBS_S1: begin
                if (state_end) begin
                    nxt_state = ebs_pkg::EBS_S2;
                end
            end
            ebs_pkg::EBS_S2: begin
                if (state_end) begin
                    nxt_state = ebs_pkg::EBS_S3;
                end
            end
            ebs_pkg::EBS_S3: begin
                if (state_end) begin
                    nxt_state = ebs_pkg::EBS_S4;
                end
            end
            ebs_pkg::EBS_S4, ebs_pkg::EBS_SW: begin
                if (state_end) begin
                    nxt_state = stretch_s4 ? ebs_pkg::EBS_SW : ebs_pkg::EBS_S5;
                end
            end
            ebs_pkg::EBS_S5: begin
                if (state_end) begin
                    nxt_state = ebs_pkg::EBS_S6;
                end
            end
            ebs_pkg::EBS_S6: begin
                if (state_end) begin
                    nxt_state = ebs_pkg::EBS_S7;
                end
            end
            ebs_pkg::EBS_S7: begin
                if (state_end) begin
                    nxt_state = ebs_pkg::EBS_IDLE;
                end
            end
            default: begin
                nxt_state = ebs_pkg::EBS_IDLE;
            end
        endcase
    end

    // State register and request capture.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_ff <= ebs_pkg::EBS_IDLE;
            write_ff <= 1'b0;
            io_ff <= 1'b0;
            cs_ff <= 4'h0;
            addr_ff <= '0;
            wdata_ff <= '0;
            mux_len_ff <= ebs_pkg::MUX_STATE_MIN;
            stb_len_ff <= ebs_pkg::STB_STATE_DEF;
        end else begin
            state_ff <= nxt_state;
            if (take_req) begin
                write_ff <= req_write_i && !req_strobe_mode_i;
                io_ff <= req_io_i;
                cs_ff <= req_chip_sel_i;
                addr_ff <= req_addr_i;
                wdata_ff <= req_wdata_i;
                mux_len_ff <= mux_state_clocks_i;
                stb_len_ff <= stb_state_clocks_i;
            end
        end
    end

    // Wait pin history: a low seen during T2 before its last clock asks for waits.
    // Sampling one clock early gives the peripheral its full clock of set-up.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wait_prev_ff <= 1'b1;
            wait_seen_ff <= 1'b0;
            ack_prev_ff <= 1'b1;
            ack_early_ff <= 1'b0;
        end else begin
            wait_prev_ff <= wait_ack_n_i;
            ack_prev_ff <= wait_ack_n_i;
            if (idle || enter_t4) begin
                wait_seen_ff <= 1'b0;
            end else if ((state_ff == ebs_pkg::EBS_T2) && !wait_prev_ff) begin
                wait_seen_ff <= 1'b1;
            end
            // Acknowledge must have been low one full clock before the S4 end edge.
            if (idle || (state_ff == ebs_pkg::EBS_S5)) begin
                ack_early_ff <= 1'b0;
            end else if (((state_ff == ebs_pkg::EBS_S4) || (state_ff == ebs_pkg::EBS_SW)) &&
                         !ack_prev_ff && !wait_ack_n_i) begin
                ack_early_ff <= 1'b1;
            end
        end
    end

    ebs_state_timer u_timer (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .tick(tick)
    );

    // Bus pin registers; states T3, S3 and S5 change nothing on purpose.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            data_oe_n_ff <= 1'b1;
            data_out_ff <= '0;
            ale_ff <= 1'b0;
            read_n_ff <= 1'b1;
            write_n_ff <= 1'b1;
            mem_req_n_ff <= 1'b1;
            io_req_n_ff <= 1'b1;
            rnw_ff <= 1'b1;
            astb_n_ff <= 1'b1;
            dstb_n_ff <= 1'b1;
            rdata_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= leave_t4 || leave_s7;
            if (take_req && !req_strobe_mode_i) begin
                data_out_ff <= req_addr_i[DATA_W-1:0];
                data_oe_n_ff <= 1'b0;
                ale_ff <= 1'b1;
            end else if (take_req) begin
                rnw_ff <= 1'b1;
            end
            if (in_t1 && tick.half) begin
                ale_ff <= 1'b0;
            end
            if (enter_t2) begin
                if (write_ff) begin
                    data_out_ff <= wdata_ff;
                    write_n_ff <= 1'b0;
                end else begin
                    data_oe_n_ff <= 1'b1;
                    read_n_ff <= 1'b0;
                end
                mem_req_n_ff <= io_ff;
                io_req_n_ff <= !io_ff;
            end
            if (enter_t4) begin
                read_n_ff <= 1'b1;
                write_n_ff <= 1'b1;
                if (!write_ff) begin
                    rdata_ff <= data_i;
                end
            end
            if (leave_t4) begin
                data_oe_n_ff <= 1'b1;
                mem_req_n_ff <= 1'b1;
                io_req_n_ff <= 1'b1;
            end
            if (enter_s2) begin
                astb_n_ff <= 1'b0;
                dstb_n_ff <= 1'b0;
            end
            if (enter_s7) begin
                rdata_ff <= data_i;
                astb_n_ff <= 1'b1;
                dstb_n_ff <= 1'b1;
            end
        end
    end

    // Chip select and address follow the captured request while a cycle runs.
    // In strobe mode the address is held from S0 onward, so it is valid on entry to S1.
    assign chip_sel_n_o = idle ? 4'hF : ~cs_ff;
    assign addr_o = addr_ff;
    assign data_o = data_out_ff;
    assign data_oe_n_o = data_oe_n_ff;
    assign addr_latch_en_o = ale_ff;
    assign read_n_o = read_n_ff;
    assign write_n_o = write_n_ff;
    assign memory_request_n_o = mem_req_n_ff;
    assign io_space_request_n_o = io_req_n_ff;
    assign read_not_write_o = rnw_ff;
    assign address_strobe_n_o = astb_n_ff;
    assign data_strobe_n_o = dstb_n_ff;
    assign inserted_wait_state_o = (state_ff == ebs_pkg::EBS_TW) ||
                                   (state_ff == ebs_pkg::EBS_SW);
    assign done_o = done_ff;
    assign rdata_o = rdata_ff;
endmodule : ebs_sequencer

// file: rtl/ebs_pkg.sv
// Package with the state codes and timing constants of the bus cycle sequencer.
package ebs_pkg;
    // Bus widths.
    localparam int ADDR_W = 24;
    localparam int DATA_W = 8;
    // Clock rate in MHz.
    localparam int CLK_MHZ = 125;
    // Allowed range of system clocks per multiplexed-mode state.
    localparam logic [3:0] MUX_STATE_MIN = 4'h2;
    localparam logic [3:0] MUX_STATE_MAX = 4'hF;
    // Clocks per strobe-mode state, reset value of the state length input.
    localparam logic [3:0] STB_STATE_DEF = 4'h2;
    // Address latch enable drops once the clocks of a state passed, times this, reach its length.
    localparam int ALE_HALF_DIV = 2;
    // Sequencer states, Gray coded from T1 to T4 and from S0 to S7 along the paths through the wait states.
    typedef enum logic [3:0] {
        EBS_IDLE = 4'h0,
        EBS_T1 = 4'h1,
        EBS_T2 = 4'h3,
        EBS_T3 = 4'h2,
        EBS_TW = 4'h6,
        EBS_T4 = 4'h7,
        EBS_S0 = 4'h5,
        EBS_S1 = 4'h4,
        EBS_S2 = 4'hC,
        EBS_S3 = 4'hD,
        EBS_S4 = 4'hF,
        EBS_SW = 4'hE,
        EBS_S5 = 4'hA,
        EBS_S6 = 4'hB,
        EBS_S7 = 4'h9
    } ebs_state_t;
endpackage : ebs_pkg

// file: rtl/ebs_tick_if.sv
// Interface carrying the state-length timer signals between sequencer and timer.
`timescale 1ns/100ps
interface ebs_tick_if;
    logic restart;
    logic [3:0] length;
    logic last;
    logic half;
    modport seq (output restart, output length, input last, input half);
    modport tmr (input restart, input length, output last, output half);
endinterface : ebs_tick_if

// file: rtl/ebs_state_timer.sv
// Counts system clocks within one bus state and flags its middle and its last clock.
`timescale 1ns/100ps
module ebs_state_timer (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    ebs_tick_if.tmr tick
);
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [4:0] twice_cnt;

    // Restart zeroes the count; otherwise it wraps at the programmed length.
    assign nxt_cnt = (tick.restart || tick.last) ? 4'h0 : 4'(cnt_ff + 4'h1);
    assign tick.last = !tick.restart && (cnt_ff == 4'(tick.length - 4'h1));
    // Half point: the clocks elapsed by this edge, the current one included, reach half the length.
    assign twice_cnt = {4'(cnt_ff + 4'h1), 1'b0};
    assign tick.half = twice_cnt >= {1'b0, tick.length};

    // Counter register.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule : ebs_state_timer

// file: verif/ebs_checker.sv
// Concurrent checks on the pins of the bus cycle sequencer.
`timescale 1ns/100ps
module ebs_seq_checker (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] mux_state_clocks_i,
    input wire logic req_ready_o,
    input wire logic done_o,
    input wire logic [7:0] rdata_o,
    input wire logic [23:0] addr_o,
    input wire logic [7:0] data_o,
    input wire logic data_oe_n_o,
    input wire logic [7:0] data_i,
    input wire logic [3:0] chip_sel_n_o,
    input wire logic addr_latch_en_o,
    input wire logic read_n_o,
    input wire logic write_n_o,
    input wire logic memory_request_n_o,
    input wire logic io_space_request_n_o,
    input wire logic read_not_write_o,
    input wire logic address_strobe_n_o,
    input wire logic data_strobe_n_o,
    input wire logic inserted_wait_state_o
);
    logic [4:0] cnt_ff;
    logic ale_ff;
    logic [4:0] exp_len;
    // Short lengths are clamped by the sequencer, so the expectation clamps too.
    assign exp_len = (mux_state_clocks_i < 4'h2) ? 5'h02 : {1'b0, mux_state_clocks_i};
    // Clocks since the latch enable rose; it wraps harmlessly while idle.
    always_ff @(posedge ref_clk_i) begin
        ale_ff <= addr_latch_en_o;
        cnt_ff <= (addr_latch_en_o && !ale_ff) ? 5'h01 : cnt_ff + 5'h01;
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Steps of the write hold and of the strobe read end.
    sequence s_write_hold;
        !data_oe_n_o && $stable(data_o) && $stable(addr_o) ##1 !data_oe_n_o && $stable(data_o);
    endsequence
    sequence s_strobe_end;
        $rose(address_strobe_n_o) && rdata_o == $past(data_i);
    endsequence
    a_ale_start_t1: assert property ($rose(addr_latch_en_o) |->
        !data_oe_n_o && data_o == addr_o[7:0] && chip_sel_n_o != 4'hF)
        else $error("Latch enable rose without address on the bus.");
    a_ale_half_t1: assert property ($fell(addr_latch_en_o) |->
        cnt_ff == ((exp_len + 5'h01) >> 1)) else $error("Latch enable fell off mid state.");
    a_mux_state_len: assert property ($fell(read_n_o) || $fell(write_n_o) |->
        cnt_ff == exp_len) else $error("First state length wrong.");
    a_read_bus_free: assert property ($fell(read_n_o) |-> data_oe_n_o &&
        memory_request_n_o != io_space_request_n_o) else $error("Read strobe with bus driven.");
    a_write_data_on: assert property ($fell(write_n_o) |-> !data_oe_n_o &&
        memory_request_n_o != io_space_request_n_o) else $error("Write strobe without data.");
    a_write_bus_hold: assert property ($rose(write_n_o) |-> s_write_hold)
        else $error("Write buses not held through last state.");
    a_mux_read_capture: assert property ($rose(read_n_o) |-> rdata_o == $past(data_i))
        else $error("Read data not captured as read strobe ended.");
    a_wait_bus_frozen: assert property (inserted_wait_state_o |-> $stable(read_n_o) &&
        $stable(write_n_o) && $stable(data_strobe_n_o) && $stable(data_oe_n_o))
        else $error("Bus signal moved during a wait.");
    a_strobe_pair_start: assert property ($fell(data_strobe_n_o) |->
        $fell(address_strobe_n_o) && read_not_write_o) else $error("Strobes did not start together.");
    a_strobe_read_end: assert property ($rose(data_strobe_n_o) |-> s_strobe_end)
        else $error("Strobe read did not end with capture.");
    a_done_idle_bus: assert property (done_o |-> req_ready_o && chip_sel_n_o == 4'hF &&
        memory_request_n_o && io_space_request_n_o && data_oe_n_o ##1 !done_o)
        else $error("Done without an idle bus.");
endmodule : ebs_seq_checker
bind ebs_sequencer ebs_seq_checker i_chk (.*);

// file: verif/ebs_periph_model.sv
// Behavioural peripheral: byte source, write sink and wait or acknowledge driver.
`timescale 1ns/100ps
module ebs_periph_model (
    input wire logic ref_clk_i,
    input wire logic [23:0] addr_o,
    input wire logic [7:0] data_o,
    input wire logic data_oe_n_o,
    input wire logic addr_latch_en_o,
    input wire logic read_n_o,
    input wire logic write_n_o,
    input wire logic data_strobe_n_o,
    input wire logic [3:0] wait_clks,
    input wire logic [3:0] ack_delay,
    output logic [7:0] data_i,
    output logic wait_ack_n_i,
    output logic [7:0] lat_addr,
    output logic [7:0] wr_byte
);
    logic ale_q, rd_q, wr_q, ack_low, drive;
    logic [3:0] wcnt_ff = 4'h0;
    logic [3:0] acnt_ff = 4'h0;
    logic [7:0] pat_ff = 8'h00;
    // Acknowledge comes a set delay after the data strobe and drops with it.
    assign ack_low = !data_strobe_n_o && acnt_ff >= ack_delay;
    assign drive = !read_n_o || ack_low;
    // A bus nobody drives shows a moving pattern, so stale bytes cannot pass.
    assign data_i = !data_oe_n_o ? data_o :
        (drive ? (read_n_o ? addr_o[7:0] ^ 8'h3C : lat_addr ^ 8'hA5) : pat_ff);
    assign wait_ack_n_i = !(ack_low || wcnt_ff != 4'h0);
    // Latch the address, take write data, and time the wait and acknowledge.
    always_ff @(posedge ref_clk_i) begin
        ale_q <= addr_latch_en_o;
        rd_q <= read_n_o;
        wr_q <= write_n_o;
        pat_ff <= pat_ff + 8'h35;
        if (ale_q && !addr_latch_en_o) lat_addr <= data_o;
        if (write_n_o && !wr_q) wr_byte <= data_o;
        if ((!read_n_o && rd_q) || (!write_n_o && wr_q)) wcnt_ff <= wait_clks;
        else if (wcnt_ff != 4'h0) wcnt_ff <= wcnt_ff - 4'h1;
        acnt_ff <= data_strobe_n_o ? 4'h0 : acnt_ff + {3'h0, acnt_ff != 4'hF};
    end
endmodule : ebs_periph_model

// file: verif/test_external_bus_cycle_sequencer.sv
// Self-checking bench for the external bus cycle sequencer.
`timescale 1ns/100ps
module test_external_bus_cycle_sequencer;
    logic ref_clk_i = 1'b0;
    logic rst_n_i, req_valid_i, req_ready_o, req_strobe_mode_i, req_write_i, req_io_i, done_o;
    logic [3:0] req_chip_sel_i, mux_state_clocks_i, stb_state_clocks_i, chip_sel_n_o;
    logic [3:0] wait_clks, ack_delay;
    logic [23:0] req_addr_i, addr_o;
    logic [7:0] req_wdata_i, rdata_o, data_o, data_i, lat_addr, wr_byte;
    logic data_oe_n_o, addr_latch_en_o, read_n_o, write_n_o, memory_request_n_o;
    logic io_space_request_n_o, read_not_write_o, address_strobe_n_o, data_strobe_n_o;
    logic wait_ack_n_i, inserted_wait_state_o, sw;
    int errors = 0, n_compared = 0, cyc = 0, n = 0;
    ebs_sequencer i_dut (.*);
    ebs_periph_model i_model (.*);
    // Free-running system clock.
    initial begin
        forever begin
            #4 ref_clk_i = ~ref_clk_i;
        end
    end
    task automatic test_done;
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    // The whole run needs a few hundred clocks; far beyond that is a hang.
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc > 3000) begin
            errors++;
            test_done();
        end
    end
    // One transfer: n ends as the cycle index of done, sw tells whether a wait showed.
    task automatic go(input logic sm, input logic wr, input logic io, input logic [3:0] cs,
        input logic [3:0] len, input logic [23:0] a, input logic [7:0] wd);
        @(negedge ref_clk_i);
        {req_strobe_mode_i, req_write_i, req_io_i, req_chip_sel_i} = {sm, wr, io, cs};
        {mux_state_clocks_i, req_addr_i, req_wdata_i, req_valid_i} = {len, a, wd, 1'b1};
        @(negedge ref_clk_i);
        req_valid_i = 1'b0;
        n = 1;
        sw = 1'b0;
        while (done_o !== 1'b1 && n < 400) begin
            sw |= inserted_wait_state_o === 1'b1;
            if (read_n_o === 1'b0 || write_n_o === 1'b0) begin
                chk(chip_sel_n_o === ~cs && memory_request_n_o === io && io_space_request_n_o === !io,
                    "select lines");
            end
            if (address_strobe_n_o === 1'b0) begin
                chk(addr_o === a && read_not_write_o === 1'b1, "strobe address");
            end
            @(negedge ref_clk_i);
            n++;
        end
    endtask : go
    task automatic t_mux_read;
        go(1'b0, 1'b0, 1'b0, 4'h1, 4'h2, 24'h123456, 8'h00);
        chk(n == 9 && !sw, "mux read length");
        chk(rdata_o === (8'h56 ^ 8'hA5), "mux read data");
    endtask : t_mux_read
    // The peripheral holds the pin low inside the second state, so a wait must appear.
    task automatic t_mux_io_wait;
        wait_clks = 4'h3;
        go(1'b0, 1'b0, 1'b1, 4'h4, 4'h5, 24'h00A7C3, 8'h00);
        chk(sw && n > 21, "mux wait missing");
        chk(rdata_o === (8'hC3 ^ 8'hA5), "mux wait data");
        wait_clks = 4'h0;
    endtask : t_mux_io_wait
    task automatic t_mux_write;
        go(1'b0, 1'b1, 1'b0, 4'h2, 4'h2, 24'h0F0E5A, 8'hC6);
        chk(n == 9 && wr_byte === 8'hC6 && lat_addr === 8'h5A, "mux write");
        go(1'b0, 1'b0, 1'b0, 4'h2, 4'h2, 24'h0F0E3B, 8'h00);
        chk(rdata_o === (8'h3B ^ 8'hA5), "read after write");
    endtask : t_mux_write
    task automatic t_mux_lengths;
        logic [3:0] lens [3] = '{4'h1, 4'h3, 4'hF};
        for (int i = 0; i < 3; i++) begin
            go(1'b0, 1'b0, 1'b0, 4'h8, lens[i], 24'h000001, 8'h00);
            chk(n == 4 * (lens[i] < 2 ? 2 : lens[i]) + 1, "mux length");
        end
    endtask : t_mux_lengths
    // Early acknowledge, then one late enough to force whole-state waits.
    task automatic t_strobe_read;
        logic [3:0] dly [2] = '{4'h1, 4'h7};
        for (int i = 0; i < 2; i++) begin
            ack_delay = dly[i];
            go(1'b1, 1'b0, 1'b0, 4'h1, 4'h2, {16'hABCD, 8'(i)}, 8'h00);
            chk(rdata_o === (8'(i) ^ 8'h3C), "strobe read data");
            chk(i == 0 ? (n == 17 && !sw) : (sw && n > 17 && (n - 17) % 2 == 0),
                "strobe length");
        end
    endtask : t_strobe_read
    initial begin
        {rst_n_i, req_valid_i, req_strobe_mode_i, req_write_i, req_io_i} = 5'h00;
        {req_chip_sel_i, req_addr_i, req_wdata_i} = 36'h000000000;
        {mux_state_clocks_i, stb_state_clocks_i, wait_clks, ack_delay} = 16'h2201;
        repeat (5) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        chk(req_ready_o === 1'b1 && chip_sel_n_o === 4'hF && data_oe_n_o === 1'b1, "reset idle");
        t_mux_read();
        t_mux_io_wait();
        t_mux_write();
        t_mux_lengths();
        t_strobe_read();
        test_done();
    end
endmodule : test_external_bus_cycle_sequencer
